// file: core/phy_error_counters_led_select.sv
`timescale 1ns/100ps
`default_nettype none
module phy_error_counters_led_select (
  input wire logic clock,
  input wire logic reset,
  input wire logic [phy_stats_pkg::reg_addr_width-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [phy_stats_pkg::data_width-1:0] reg_wdata,
  output logic [phy_stats_pkg::data_width-1:0] reg_rdata,
  input wire logic disconnect_enable,
  input wire logic false_carrier_event,
  input wire logic disconnect_event,
  input wire logic rx_frame_active,
  input wire logic rx_error,
  input wire logic bad_symbol,
  input wire logic premature_end_event,
  input wire logic tenbase_frame_end_event,
  input wire logic jabber_event,
  input wire logic activity,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic collision,
  output logic activity_indicator_output,
  output logic link_indicator_output
);
  import phy_stats_pkg::*;

  logic [15:0] cnt_false_carrier;
  logic [15:0] cnt_disconnect;
  logic [15:0] cnt_error_frame;
  logic [15:0] cnt_symbol;
  logic [15:0] cnt_premature;
  logic [15:0] cnt_tenbase;
  logic [15:0] cnt_jabber;
  logic [15:0] equalizer_q;
  logic [2:0] led_select_q;
  logic [15:0] rdata_d;
  logic frame_errored_q;
  logic frame_error_pulse;
  logic symbol_group_pulse;
  logic disconnect_counted;
  logic clear_false_carrier;
  logic clear_disconnect;
  logic clear_error_frame;
  logic clear_symbol;
  logic clear_premature;
  logic clear_tenbase;
  logic clear_jabber;
  logic equalizer_write;
  logic led_select_write;
  logic act_d;
  logic link_d;

  // a read of a counter is its clear strobe, so the address must stand with the strobe
  assign clear_false_carrier = reg_read && (reg_addr == false_carrier_count_offset);
  assign clear_disconnect = reg_read && (reg_addr == disconnect_event_count_offset);
  assign clear_error_frame = reg_read && (reg_addr == error_frame_count_offset);
  assign clear_symbol = reg_read && (reg_addr == symbol_error_count_offset);
  assign clear_premature = reg_read && (reg_addr == premature_frame_end_count_offset);
  assign clear_tenbase = reg_read && (reg_addr == tenbase_frame_end_error_count_offset);
  assign clear_jabber = reg_read && (reg_addr == jabber_event_count_offset);

  // counter registers have no write path; only these two take reg_wdata
  assign equalizer_write = reg_write && (reg_addr == equalizer_reserved_offset);
  assign led_select_write = reg_write && (reg_addr == led_select_control_offset);

  // the enable bit lives outside this block and is taken as a plain level
  assign disconnect_counted = disconnect_event && disconnect_enable;

  // one error per frame: flag latches first error, cleared at frame end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_errored_q <= 1'b0;
    end else if (!rx_frame_active) begin
      frame_errored_q <= 1'b0;
    end else if (rx_error) begin
      frame_errored_q <= 1'b1;
    end
  end

  assign frame_error_pulse = rx_frame_active && rx_error && !frame_errored_q;

  symbol_run_grouper u_symbol_grouper (
    .clock(clock),
    .reset(reset),
    .frame_active(rx_frame_active),
    .bad_symbol(bad_symbol),
    .group_pulse_q(symbol_group_pulse)
  );

  sat_read_clear_counter u_false_carrier (
    .clock(clock),
    .reset(reset),
    .count_event(false_carrier_event),
    .read_clear(clear_false_carrier),
    .count_q(cnt_false_carrier)
  );

  sat_read_clear_counter u_disconnect (
    .clock(clock),
    .reset(reset),
    .count_event(disconnect_counted),
    .read_clear(clear_disconnect),
    .count_q(cnt_disconnect)
  );

  sat_read_clear_counter u_error_frame (
    .clock(clock),
    .reset(reset),
    .count_event(frame_error_pulse),
    .read_clear(clear_error_frame),
    .count_q(cnt_error_frame)
  );

  sat_read_clear_counter u_symbol (
    .clock(clock),
    .reset(reset),
    .count_event(symbol_group_pulse),
    .read_clear(clear_symbol),
    .count_q(cnt_symbol)
  );

  sat_read_clear_counter u_premature (
    .clock(clock),
    .reset(reset),
    .count_event(premature_end_event),
    .read_clear(clear_premature),
    .count_q(cnt_premature)
  );

  sat_read_clear_counter u_tenbase (
    .clock(clock),
    .reset(reset),
    .count_event(tenbase_frame_end_event),
    .read_clear(clear_tenbase),
    .count_q(cnt_tenbase)
  );

  sat_read_clear_counter u_jabber (
    .clock(clock),
    .reset(reset),
    .count_event(jabber_event),
    .read_clear(clear_jabber),
    .count_q(cnt_jabber)
  );

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      equalizer_q <= equalizer_reset_value;
    end else if (equalizer_write) begin
      equalizer_q <= reg_wdata;
    end
  end

  // reserved bits 15:3 are not stored; software is expected to write zero there
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      led_select_q <= led_select_reset_value;
    end else if (led_select_write) begin
      led_select_q <= reg_wdata[2:0];
    end
  end

  // read data is the value before the clear that the same read causes
  always_comb begin
    case (reg_addr)
      false_carrier_count_offset: begin
        rdata_d = cnt_false_carrier;
      end
      disconnect_event_count_offset: begin
        rdata_d = cnt_disconnect;
      end
      error_frame_count_offset: begin
        rdata_d = cnt_error_frame;
      end
      symbol_error_count_offset: begin
        rdata_d = cnt_symbol;
      end
      premature_frame_end_count_offset: begin
        rdata_d = cnt_premature;
      end
      tenbase_frame_end_error_count_offset: begin
        rdata_d = cnt_tenbase;
      end
      jabber_event_count_offset: begin
        rdata_d = cnt_jabber;
      end
      equalizer_reserved_offset: begin
        rdata_d = equalizer_q;
      end
      led_select_control_offset: begin
        rdata_d = {13'h0, led_select_q};
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end

  // off is the safe choice for any code without a defined meaning
  always_comb begin
    case (led_mode_t'(led_select_q))
      led_act_link: begin
        act_d = activity;
      end
      led_speed_coll: begin
        act_d = speed_100;
      end
      led_speed_link: begin
        act_d = speed_100;
      end
      led_act_coll: begin
        act_d = activity;
      end
      led_both_off: begin
        act_d = 1'b0;
      end
      led_undefined: begin
        act_d = 1'b0;
      end
      led_first_on: begin
        act_d = 1'b1;
      end
      led_both_on: begin
        act_d = 1'b1;
      end
      default: begin
        act_d = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (led_mode_t'(led_select_q))
      led_act_link: begin
        link_d = link_up;
      end
      led_speed_coll: begin
        link_d = collision;
      end
      led_speed_link: begin
        link_d = link_up;
      end
      led_act_coll: begin
        link_d = collision;
      end
      led_both_off: begin
        link_d = 1'b0;
      end
      led_undefined: begin
        link_d = 1'b0;
      end
      led_first_on: begin
        link_d = 1'b0;
      end
      led_both_on: begin
        link_d = 1'b1;
      end
      default: begin
        link_d = 1'b0;
      end
    endcase
  end

  // registered so a mode change never glitches the pins, at the cost of one cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      activity_indicator_output <= 1'b0;
    end else begin
      activity_indicator_output <= act_d;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      link_indicator_output <= 1'b0;
    end else begin
      link_indicator_output <= link_d;
    end
  end
endmodule : phy_error_counters_led_select
`default_nettype wire

// file: core/phy_stats_pkg.sv
package phy_stats_pkg;
  localparam int reg_addr_width = 5;
  localparam int data_width = 16;
  localparam logic [4:0] phy_unit_control_offset = 5'h10;
  localparam logic [4:0] false_carrier_count_offset = 5'h13;
  localparam logic [4:0] disconnect_event_count_offset = 5'h14;
  localparam logic [4:0] error_frame_count_offset = 5'h15;
  localparam logic [4:0] symbol_error_count_offset = 5'h16;
  localparam logic [4:0] premature_frame_end_count_offset = 5'h17;
  localparam logic [4:0] tenbase_frame_end_error_count_offset = 5'h18;
  localparam logic [4:0] jabber_event_count_offset = 5'h19;
  localparam logic [4:0] equalizer_reserved_offset = 5'h1a;
  localparam logic [4:0] led_select_control_offset = 5'h1b;
  localparam int disconnect_enable_bit = 13;
  localparam int led_field_width = 3;
  localparam logic [15:0] counter_reset_value = 16'h0000;
  localparam logic [15:0] equalizer_reset_value = 16'h0000;
  localparam logic [2:0] led_select_reset_value = 3'h0;
  localparam logic [2:0] symbol_run_length = 3'h6;
  typedef enum logic [2:0] {
    led_act_link, led_speed_coll, led_speed_link, led_act_coll,
    led_both_off, led_undefined, led_first_on, led_both_on
  } led_mode_t;
endpackage : phy_stats_pkg

// file: core/sat_read_clear_counter.sv
`timescale 1ns/100ps
`default_nettype none
module sat_read_clear_counter (
  input wire logic clock,
  input wire logic reset,
  input wire logic count_event,
  input wire logic read_clear,
  output logic [15:0] count_q
);
  import phy_stats_pkg::*;
  // an event in the read cycle is kept as the new count so it is not lost
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= counter_reset_value;
    end else if (read_clear) begin
      count_q <= {15'h0, count_event};
    end else if (count_event && (count_q != 16'hffff)) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule : sat_read_clear_counter
`default_nettype wire

// file: core/symbol_run_grouper.sv
`timescale 1ns/100ps
`default_nettype none
module symbol_run_grouper (
  input wire logic clock,
  input wire logic reset,
  input wire logic frame_active,
  input wire logic bad_symbol,
  output logic group_pulse_q
);
  import phy_stats_pkg::*;
  logic [2:0] run_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      run_q <= 3'h0;
      group_pulse_q <= 1'b0;
    end else begin
      group_pulse_q <= 1'b0;
      if (!frame_active || !bad_symbol) begin
        run_q <= 3'h0;
      end else if (run_q == 3'h0) begin
        group_pulse_q <= 1'b1;
        run_q <= (symbol_run_length == 3'h1) ? 3'h0 : 3'h1;
      end else if (run_q == symbol_run_length - 3'h1) begin
        run_q <= 3'h0;
      end else begin
        run_q <= run_q + 3'h1;
      end
    end
  end
endmodule : symbol_run_grouper
`default_nettype wire

// file: verif/mgmt_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module mgmt_ctrl_model (
  input wire logic clock,
  output logic [phy_stats_pkg::reg_addr_width-1:0] reg_addr,
  output logic reg_read,
  output logic reg_write,
  output logic [phy_stats_pkg::data_width-1:0] reg_wdata
);
  import phy_stats_pkg::*;
  initial begin
    reg_addr = 5'h00;
    reg_read = 1'b0;
    reg_write = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one request per call, entered at a falling edge and held across the rising edge
  task automatic acc(input logic rd, input logic wr, input logic [4:0] a, input logic [15:0] d);
    reg_read = rd;
    reg_write = wr;
    // idle bus lines toggle so a stale value is never mistaken for a request
    reg_addr = (rd || wr) ? a : ~reg_addr;
    reg_wdata = !wr ? ~reg_wdata : (a == led_select_control_offset) ? {13'h0, d[2:0]} : d;
    @(negedge clock);
  endtask : acc
endmodule : mgmt_ctrl_model
`default_nettype wire

// file: verif/phy_error_counters_led_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module phy_error_counters_led_select_tb_top;
  import phy_stats_pkg::*;
  logic clock, reset, disconnect_enable, activity, link_up, speed_100, collision, act_led, link_led, rd_seen;
  logic [7:0] ev;
  logic [4:0] reg_addr;
  logic reg_read, reg_write;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [15:0] exp_q[$];
  logic [4:0] caddr[5] = '{5'h13, 5'h14, 5'h17, 5'h18, 5'h19};
  int bad_count, tests_run, seed, cycles, n;
  mgmt_ctrl_model i_mgmt (.clock(clock), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
    .reg_wdata(reg_wdata));
  phy_error_counters_led_select i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .disconnect_enable(disconnect_enable), .false_carrier_event(ev[7]), .disconnect_event(ev[6]),
    .premature_end_event(ev[5]), .tenbase_frame_end_event(ev[4]), .jabber_event(ev[3]),
    .rx_frame_active(ev[2]), .rx_error(ev[1]), .bad_symbol(ev[0]), .activity(activity), .link_up(link_up),
    .speed_100(speed_100), .collision(collision), .activity_indicator_output(act_led),
    .link_indicator_output(link_led));
  task automatic print_verdict;
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic cyc(input logic wr, input logic [4:0] a, input logic [15:0] dv, input logic [7:0] e);
    ev = e;
    i_mgmt.acc(1'b0, wr, a, dv);
  endtask : cyc
  task automatic rd(input logic [4:0] a, input logic [15:0] x, input logic [7:0] e);
    exp_q.push_back(x);
    ev = e;
    i_mgmt.acc(1'b1, 1'b0, a, 16'h0000);
  endtask : rd
  task automatic check(input logic [15:0] x);
    tests_run++;
    if (reg_rdata !== x) begin
      bad_count++;
      $display("MISMATCH reg_rdata expected %h seen %h", x, reg_rdata);
    end
  endtask : check
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) rd_seen <= reg_read;
  always @(negedge clock) if (rd_seen) check(exp_q.pop_front());
  always @(negedge clock) {activity, link_up, speed_100, collision} <= 4'($random(seed));
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    seed = 32'h84c0;
    reset = 1'b1;
    rd_seen = 1'b0;
    ev = 8'h00;
    disconnect_enable = 1'b1;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    for (int a = 19; a <= 27; a++) rd(5'(a), 16'h0000, 8'h00);
    for (int k = 0; k < 5; k++) begin
      n = 1 + ($unsigned($random(seed)) % 20);
      for (int i = 0; i < n; i++) begin
        cyc(1'b0, 5'h00, 16'h0000, 8'h80 >> k);
        repeat ($unsigned($random(seed)) % 3) cyc(1'b0, 5'h00, 16'h0000, 8'h00);
      end
      rd(caddr[k], 16'(n), 8'h80 >> k);
      rd(caddr[k], 16'h0001, 8'h00);
      rd(caddr[k], 16'h0000, 8'h00);
    end
    disconnect_enable = 1'b0;
    repeat (4) cyc(1'b0, 5'h00, 16'h0000, 8'h40);
    rd(5'h14, 16'h0000, 8'h40);
    rd(5'h14, 16'h0000, 8'h00);
    disconnect_enable = 1'b1;
    cyc(1'b0, 5'h00, 16'h0000, 8'h04);
    repeat (3) cyc(1'b0, 5'h00, 16'h0000, 8'h06);
    cyc(1'b0, 5'h00, 16'h0000, 8'h00);
    cyc(1'b0, 5'h00, 16'h0000, 8'h06);
    cyc(1'b0, 5'h00, 16'h0000, 8'h02);
    rd(5'h15, 16'h0002, 8'h00);
    cyc(1'b0, 5'h00, 16'h0000, 8'h04);
    repeat (7) cyc(1'b0, 5'h00, 16'h0000, 8'h05);
    cyc(1'b0, 5'h00, 16'h0000, 8'h04);
    repeat (2) cyc(1'b0, 5'h00, 16'h0000, 8'h05);
    repeat (2) cyc(1'b0, 5'h00, 16'h0000, 8'h01);
    repeat (2) cyc(1'b0, 5'h00, 16'h0000, 8'h00);
    rd(5'h16, 16'h0003, 8'h00);
    repeat (65540) cyc(1'b0, 5'h00, 16'h0000, 8'h40);
    rd(5'h14, 16'hffff, 8'h00);
    d = 16'($random(seed));
    cyc(1'b1, 5'h1a, d, 8'h00);
    rd(5'h1a, d, 8'h00);
    cyc(1'b1, 5'h13, d, 8'h00);
    rd(5'h13, 16'h0000, 8'h00);
    rd(5'h1c, 16'h0000, 8'h00);
    for (int m = 0; m < 8; m++) begin
      cyc(1'b1, 5'h1b, 16'($random(seed)) & 16'hfff8 | 16'(m), 8'h00);
      rd(5'h1b, 16'(m), 8'h00);
      repeat (6) cyc(1'b0, 5'h00, 16'h0000, 8'h00);
    end
    reset = 1'b1;
    cyc(1'b0, 5'h00, 16'h0000, 8'h00);
    reset = 1'b0;
    rd(5'h1b, 16'h0000, 8'h00);
    repeat (2) cyc(1'b0, 5'h00, 16'h0000, 8'h00);
    print_verdict();
  end
endmodule : phy_error_counters_led_select_tb_top
`default_nettype wire

// file: verif/phy_stats_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module phy_stats_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic [phy_stats_pkg::reg_addr_width-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [phy_stats_pkg::data_width-1:0] reg_wdata,
  input wire logic [phy_stats_pkg::data_width-1:0] reg_rdata,
  input wire logic disconnect_enable,
  input wire logic false_carrier_event,
  input wire logic activity,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic collision,
  input wire logic activity_indicator_output,
  input wire logic link_indicator_output
);
  import phy_stats_pkg::*;
  logic [2:0] mode_q;
  // shadow of the led field, only the write path can move it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_q <= 3'h0;
    end else if (reg_write && reg_addr == led_select_control_offset) begin
      mode_q <= reg_wdata[2:0];
    end
  end
  function automatic logic led_f(input logic sel, input logic [2:0] m, input logic a, l, s, c);
    case (m)
      3'h0: return sel ? l : a;
      3'h1: return sel ? c : s;
      3'h2: return sel ? l : s;
      3'h3: return sel ? c : a;
      3'h6: return !sel;
      3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : led_f
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_rdata_hold;
    !$past(reg_read) && !$past(reset) |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_unmapped;
    reg_read && (reg_addr < 5'h13 || reg_addr > 5'h1b) |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_led_reg;
    reg_read && reg_addr == 5'h1b |=> reg_rdata == {13'h0000, $past(mode_q)};
  endproperty
  a_led_reg: assert property (p_led_reg) else $error("led register readback wrong");
  property p_act;
    !$past(reset) |-> activity_indicator_output ==
      led_f(1'b0, $past(mode_q), $past(activity), $past(link_up), $past(speed_100), $past(collision));
  endproperty
  a_act: assert property (p_act) else $error("activity led wrong");
  property p_link;
    !$past(reset) |-> link_indicator_output ==
      led_f(1'b1, $past(mode_q), $past(activity), $past(link_up), $past(speed_100), $past(collision));
  endproperty
  a_link: assert property (p_link) else $error("link led wrong");
  property p_fc_clear;
    (reg_read && reg_addr == 5'h13 && !false_carrier_event) ##1 (reg_read && reg_addr == 5'h13)
      |=> reg_rdata == 16'h0000;
  endproperty
  a_fc_clear: assert property (p_fc_clear) else $error("count not cleared by read");
  property p_disc_off;
    (reg_read && reg_addr == 5'h14 && !disconnect_enable) ##1 (reg_read && reg_addr == 5'h14)
      |=> reg_rdata == 16'h0000;
  endproperty
  a_disc_off: assert property (p_disc_off) else $error("disconnect counted while off");
  property p_eq;
    (reg_write && reg_addr == 5'h1a) ##1 (reg_read && reg_addr == 5'h1a) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_eq: assert property (p_eq) else $error("reserved register lost write");
endmodule : phy_stats_monitor
bind phy_error_counters_led_select phy_stats_monitor i_monitor (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .disconnect_enable(disconnect_enable), .false_carrier_event(false_carrier_event),
  .activity(activity), .link_up(link_up), .speed_100(speed_100), .collision(collision),
  .activity_indicator_output(activity_indicator_output), .link_indicator_output(link_indicator_output));
`default_nettype wire
